// [common/bcc_pkg.sv]
// Constants, register map and bus carrier types for the baseband clock control block
package bcc_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ        = 50_000_000;
  localparam int unsigned CORE_PERIOD_NS     = 20;
  // Slow reference period, 32.768 kHz, in ns (rounded down to whole ns)
  localparam int unsigned SLOW_PERIOD_NS     = 30_517;
  // Absent after two full slow periods without any edge; a longest time rounds down
  localparam int unsigned SLOW_TIMEOUT_NS    = 2 * SLOW_PERIOD_NS;
  localparam int unsigned SLOW_TIMEOUT_CYC   = SLOW_TIMEOUT_NS / CORE_PERIOD_NS;
  localparam int unsigned SLOW_CNT_W         = 12;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_PWR_EXT        = 8'h2D;
  localparam logic [7:0]  IDX_CLK_EN_PLL     = 8'h55;
  localparam logic [7:0]  IDX_IDLE_CTL       = 8'h70;
  localparam logic [7:0]  IDX_CLK_STATUS     = 8'h71;
  localparam int unsigned WB_ADR_W           = 12;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned PWR_RADIO_BIT      = 1;
  localparam int unsigned PWR_DSP_BIT        = 2;
  localparam int unsigned PWR_GP_BIT         = 4;
  localparam int unsigned PWR_OUT_CLK_EN_BIT = 5;
  localparam logic [7:0]  PWR_EXT_MASK       = 8'h36;
  localparam logic [7:0]  PWR_EXT_RESET      = 8'h20;

  localparam int unsigned CEP_SERIAL_BIT     = 5;
  localparam int unsigned CEP_SECOND_BIT     = 4;
  localparam int unsigned CEP_FIRST_BIT      = 3;
  localparam int unsigned CEP_PLL_LSB        = 0;
  localparam int unsigned CEP_PLL_W          = 3;
  localparam logic [7:0]  CEP_MASK           = 8'h3F;
  localparam logic [7:0]  CEP_RESET          = 8'h00;

  localparam int unsigned IDLE_PD_BIT        = 0;
  localparam logic [7:0]  IDLE_MASK          = 8'h01;
  localparam logic [7:0]  IDLE_RESET         = 8'h00;

  localparam int unsigned ST_SLOW_PRESENT    = 0;
  localparam int unsigned ST_FAST_OSC_ON     = 1;
  localparam int unsigned ST_GATE_OPEN       = 2;
  localparam int unsigned ST_SLOW_LOST       = 3;

  // ---------------------------------------------------------------------------
  // Wishbone carrier
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [WB_ADR_W-1:0] adr;
    logic [3:0]          sel;
    logic [31:0]         dat;
  } bcc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } bcc_wb_rsp_t;

endpackage

// [hw/bcc_clock_gate.sv]
// Glitch-free clock gate for the converter clock output
`timescale 1ns/1ns
module bcc_clock_gate
(
  input  wire logic i_clk,
  input  wire logic i_enable,
  output logic      o_gate_open,
  output logic      o_gated_clk
);
  import bcc_pkg::*;

  logic enable_latched;

  // ---------------------------------------------------------------------------
  // Latch is transparent only while the clock is low
  // ---------------------------------------------------------------------------
  // A flop-based gate would cut a high phase short; the low-phase latch cannot
  always_latch
  begin
    if (!i_clk)
    begin
      enable_latched <= i_enable;
    end
  end

  assign o_gated_clk = i_clk & enable_latched;
  assign o_gate_open = enable_latched;

endmodule // bcc_clock_gate

// [hw/bcc_slow_detect.sv]
// Presence detector for the 32.768 kHz slow reference clock
`timescale 1ns/1ns
module bcc_slow_detect
(
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  input  wire logic i_slow_level,
  output logic      o_present
);
  import bcc_pkg::*;

  localparam logic [SLOW_CNT_W-1:0] TIMEOUT = SLOW_CNT_W'(SLOW_TIMEOUT_CYC);

  logic                  level_q;
  logic                  seen_q;
  logic                  edge_seen;
  logic [SLOW_CNT_W-1:0] quiet_q;
  logic [SLOW_CNT_W-1:0] quiet_d;
  logic                  present_q;
  logic                  present_d;

  // ---------------------------------------------------------------------------
  // Edge watch and quiet-time counter
  // ---------------------------------------------------------------------------
  // The first sample after reset is not compared, so no false edge is taken
  assign edge_seen = seen_q && (i_slow_level != level_q);
  assign quiet_d   = edge_seen ? '0 :
                     (quiet_q == TIMEOUT) ? quiet_q : quiet_q + 1'b1;
  assign present_d = edge_seen ? 1'b1 : (quiet_q == TIMEOUT) ? 1'b0 : present_q;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      level_q   <= 1'b0;
      seen_q    <= 1'b0;
      quiet_q   <= '0;
      present_q <= 1'b0;
    end
    else
    begin
      level_q   <= i_slow_level;
      seen_q    <= 1'b1;
      quiet_q   <= quiet_d;
      present_q <= present_d;
    end
  end

  assign o_present = present_q;

endmodule // bcc_slow_detect

// [hw/bcc_top.sv]
// Baseband clock control: clock routing, converter clock gate, slow clocking, registers
`timescale 1ns/1ns
module bcc_top
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset,
  input  wire bcc_pkg::bcc_wb_req_t  i_wb_req,
  output bcc_pkg::bcc_wb_rsp_t       o_wb_rsp,
  input  wire logic                  i_slow_crystal_in,
  output logic                       o_cpu_clk,
  output logic                       o_codec_clk,
  output logic                       o_converter_clock_out,
  output logic                       o_fast_osc_power_ctl,
  output logic                       o_radio_power_ctl,
  output logic                       o_dsp_power_ctl,
  output logic                       o_gp_power_ctl,
  output logic                       o_serial_conn_clock_enable,
  output logic                       o_second_port_clock_enable,
  output logic                       o_first_port_clock_enable,
  output logic [2:0]                 o_signal_proc_pll_setting
);
  import bcc_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [7:0]  pwr_ext_q;
  logic [7:0]  pwr_ext_d;
  logic [7:0]  clk_en_pll_q;
  logic [7:0]  clk_en_pll_d;
  logic [7:0]  idle_ctl_q;
  logic [7:0]  idle_ctl_d;
  logic        slow_lost_q;
  logic        slow_lost_d;
  logic        slow_present_q;
  logic        fast_osc_q;
  logic        fast_osc_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  logic        slow_present;
  logic        gate_open;
  logic        bus_req;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [9:0]  reg_index;
  logic        word_aligned;
  logic        hit_pwr_ext;
  logic        hit_clk_en_pll;
  logic        hit_idle_ctl;
  logic        hit_clk_status;
  logic        lane0_wr;
  logic [7:0]  wr_byte;
  logic [7:0]  status_byte;
  logic [7:0]  rd_byte;
  logic        slow_fell;
  logic        lost_clear;

  // ---------------------------------------------------------------------------
  // Main clock routing
  // ---------------------------------------------------------------------------
  // Both consumers take the main clock itself, never through a gate
  assign o_cpu_clk   = i_core_clk;
  assign o_codec_clk = i_core_clk;

  // ---------------------------------------------------------------------------
  // Converter clock gate
  // ---------------------------------------------------------------------------
  // Enable flag resets to one, so the output keeps toggling through reset
  bcc_clock_gate u_gate
  (
    .i_clk       (i_core_clk),
    .i_enable    (pwr_ext_q[PWR_OUT_CLK_EN_BIT]),
    .o_gate_open (gate_open),
    .o_gated_clk (o_converter_clock_out)
  );

  // ---------------------------------------------------------------------------
  // Slow clock presence
  // ---------------------------------------------------------------------------
  bcc_slow_detect u_slow
  (
    .i_core_clk   (i_core_clk),
    .i_reset      (i_reset),
    .i_slow_level (i_slow_crystal_in),
    .o_present    (slow_present)
  );

  // Fast oscillator may drop only when idle asks and the slow clock keeps time
  assign fast_osc_d = !(idle_ctl_q[IDLE_PD_BIT] && slow_present);

  // ---------------------------------------------------------------------------
  // Wishbone decode
  // ---------------------------------------------------------------------------
  assign bus_req        = i_wb_req.cyc && i_wb_req.stb;
  assign reg_index      = i_wb_req.adr[WB_ADR_W-1:2];
  assign word_aligned   = (i_wb_req.adr[1:0] == 2'h0);
  assign hit_pwr_ext    = word_aligned && (reg_index == {2'h0, IDX_PWR_EXT});
  assign hit_clk_en_pll = word_aligned && (reg_index == {2'h0, IDX_CLK_EN_PLL});
  assign hit_idle_ctl   = word_aligned && (reg_index == {2'h0, IDX_IDLE_CTL});
  assign hit_clk_status = word_aligned && (reg_index == {2'h0, IDX_CLK_STATUS});

  // An access is taken on the edge where the answer is raised, exactly once
  assign wr_strobe      = bus_req && !ack_q && i_wb_req.we;
  assign rd_strobe      = bus_req && !ack_q && !i_wb_req.we;
  assign lane0_wr       = wr_strobe && i_wb_req.sel[0];
  assign wr_byte        = i_wb_req.dat[7:0];

  // ---------------------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------------------
  assign pwr_ext_d      = (lane0_wr && hit_pwr_ext) ?
                          (wr_byte & PWR_EXT_MASK) : pwr_ext_q;
  assign clk_en_pll_d   = (lane0_wr && hit_clk_en_pll) ?
                          (wr_byte & CEP_MASK) : clk_en_pll_q;
  assign idle_ctl_d     = (lane0_wr && hit_idle_ctl) ?
                          (wr_byte & IDLE_MASK) : idle_ctl_q;

  // Lost flag: write one to clear, and a new loss in the same cycle wins
  assign slow_fell      = slow_present_q && !slow_present;
  assign lost_clear     = lane0_wr && hit_clk_status && wr_byte[ST_SLOW_LOST];
  assign slow_lost_d    = slow_fell ? 1'b1 : (lost_clear ? 1'b0 : slow_lost_q);

  // ---------------------------------------------------------------------------
  // Read data and acknowledge
  // ---------------------------------------------------------------------------
  assign status_byte    = {4'h0, slow_lost_q, gate_open, fast_osc_q, slow_present};
  // Unmapped addresses answer with zero and ignore writes, so the bus never hangs
  assign rd_byte        = hit_pwr_ext    ? pwr_ext_q    :
                          hit_clk_en_pll ? clk_en_pll_q :
                          hit_idle_ctl   ? idle_ctl_q   :
                          hit_clk_status ? status_byte  : 8'h00;
  assign rdata_d        = rd_strobe ? {24'h000000, rd_byte} : rdata_q;
  assign ack_d          = bus_req && !ack_q;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      pwr_ext_q      <= PWR_EXT_RESET;
      clk_en_pll_q   <= CEP_RESET;
      idle_ctl_q     <= IDLE_RESET;
      slow_lost_q    <= 1'b0;
      slow_present_q <= 1'b0;
      fast_osc_q     <= 1'b1;
      ack_q          <= 1'b0;
      rdata_q        <= 32'h00000000;
    end
    else
    begin
      pwr_ext_q      <= pwr_ext_d;
      clk_en_pll_q   <= clk_en_pll_d;
      idle_ctl_q     <= idle_ctl_d;
      slow_lost_q    <= slow_lost_d;
      slow_present_q <= slow_present;
      fast_osc_q     <= fast_osc_d;
      ack_q          <= ack_d;
      rdata_q        <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_wb_rsp.ack                 = ack_q;
  assign o_wb_rsp.dat                 = rdata_q;
  assign o_fast_osc_power_ctl         = fast_osc_q;
  assign o_radio_power_ctl            = pwr_ext_q[PWR_RADIO_BIT];
  assign o_dsp_power_ctl              = pwr_ext_q[PWR_DSP_BIT];
  assign o_gp_power_ctl               = pwr_ext_q[PWR_GP_BIT];
  assign o_serial_conn_clock_enable   = clk_en_pll_q[CEP_SERIAL_BIT];
  assign o_second_port_clock_enable   = clk_en_pll_q[CEP_SECOND_BIT];
  assign o_first_port_clock_enable    = clk_en_pll_q[CEP_FIRST_BIT];
  assign o_signal_proc_pll_setting    = clk_en_pll_q[CEP_PLL_LSB +: CEP_PLL_W];

endmodule // bcc_top

// [sim/bcc_top_checker.sv]
// Port-level assertions for the baseband clock control block
`timescale 1ns/1ns
module bcc_top_checker
(
  input wire logic                 i_core_clk,
  input wire logic                 i_reset,
  input wire bcc_pkg::bcc_wb_req_t i_wb_req,
  input wire bcc_pkg::bcc_wb_rsp_t o_wb_rsp,
  input wire logic                 i_slow_crystal_in,
  input wire logic                 o_cpu_clk,
  input wire logic                 o_codec_clk,
  input wire logic                 o_converter_clock_out,
  input wire logic                 o_fast_osc_power_ctl,
  input wire logic                 o_radio_power_ctl,
  input wire logic                 o_dsp_power_ctl,
  input wire logic                 o_gp_power_ctl,
  input wire logic                 o_serial_conn_clock_enable,
  input wire logic                 o_second_port_clock_enable,
  input wire logic                 o_first_port_clock_enable,
  input wire logic [2:0]           o_signal_proc_pll_setting
);
  import bcc_pkg::*;
  // ---------------------------------------------------------------------------
  // Mirrors of the control bits
  // ---------------------------------------------------------------------------
  wire take = i_wb_req.cyc & i_wb_req.stb & ~o_wb_rsp.ack;
  wire wr0  = take & i_wb_req.we & i_wb_req.sel[0];
  logic        en_q;
  logic        idle_q;
  logic        slow_q;
  logic [11:0] quiet_q;
  // Quiet count is conservative: it restarts on reset, so it never overclaims
  always_ff @(posedge i_core_clk)
  begin
    slow_q  <= i_slow_crystal_in;
    quiet_q <= (i_reset || slow_q != i_slow_crystal_in) ? 12'h000 :
               (quiet_q == 12'hFFF) ? quiet_q : quiet_q + 12'h001;
    if (i_reset)
    begin
      en_q   <= 1'b1;
      idle_q <= 1'b0;
    end
    else if (wr0 && i_wb_req.adr == 12'h0B4)
      en_q <= i_wb_req.dat[PWR_OUT_CLK_EN_BIT];
    else if (wr0 && i_wb_req.adr == 12'h1C0)
      idle_q <= i_wb_req.dat[IDLE_PD_BIT];
  end
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  AST_ACK_NEXT: assert property (take |=> o_wb_rsp.ack) else $error("ack late");
  AST_ACK_PULSE: assert property (o_wb_rsp.ack |=> !o_wb_rsp.ack) else $error("ack long");
  AST_RD_UPPER: assert property (o_wb_rsp.ack |-> o_wb_rsp.dat[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_CEP_WR: assert property (wr0 && i_wb_req.adr == 12'h154 |=>
    {o_serial_conn_clock_enable, o_second_port_clock_enable, o_first_port_clock_enable,
     o_signal_proc_pll_setting} == $past(i_wb_req.dat[5:0])) else $error("enables wrong");
  AST_PWR_WR: assert property (wr0 && i_wb_req.adr == 12'h0B4 |=>
    {o_gp_power_ctl, o_dsp_power_ctl, o_radio_power_ctl} ==
    {$past(i_wb_req.dat[4]), $past(i_wb_req.dat[2]), $past(i_wb_req.dat[1])})
    else $error("power controls wrong");
  AST_CLK_ROUTE: assert property (@(i_core_clk) o_cpu_clk == i_core_clk &&
    o_codec_clk == i_core_clk) else $error("core clock routing wrong");
  AST_GATE_HIGH: assert property (@(negedge i_core_clk) en_q == $past(en_q) |->
    o_converter_clock_out == en_q) else $error("converter clock gate wrong");
  AST_GATE_LOW: assert property (!o_converter_clock_out) else $error("runt pulse");
  // A whole high phase must carry the flag as it stood before that rising edge
  AST_GATE_FULL: assert property (@(negedge i_core_clk)
    o_converter_clock_out == $past(en_q)) else $error("converter clock pulse cut short");
  AST_OSC_IDLE: assert property (!idle_q && !$past(idle_q) |-> o_fast_osc_power_ctl)
    else $error("oscillator off outside idle");
  AST_OSC_SLOW: assert property (quiet_q >= 12'hC08 |-> o_fast_osc_power_ctl)
    else $error("oscillator off without slow clock");
  cover property (wr0 && i_wb_req.adr == 12'h0B4 && !i_wb_req.dat[5]);
  cover property ($fell(o_fast_osc_power_ctl));
  cover property (take && !i_wb_req.we && i_wb_req.adr == 12'h154);
endmodule // bcc_top_checker

bind bcc_top bcc_top_checker bcc_top_checker_i (.*);

// [sim/bcc_slow_osc.sv]
// Model of the external slow reference oscillator
`timescale 1ns/1ns
module bcc_slow_osc
#(
  parameter int unsigned HALF_CYC = 763
)
(
  input  wire logic i_core_clk,
  input  wire logic i_run,
  output logic      o_slow
);
  logic [11:0] cnt_q  = 12'h000;
  logic        slow_q = 1'b0;
  assign o_slow = slow_q;
  // Stopped oscillator holds its level, as a dead crystal would
  always_ff @(posedge i_core_clk)
  begin
    if (i_run)
    begin
      cnt_q  <= (cnt_q == 12'(HALF_CYC - 1)) ? 12'h000 : cnt_q + 12'h001;
      slow_q <= (cnt_q == 12'(HALF_CYC - 1)) ? ~slow_q : slow_q;
    end
  end
endmodule // bcc_slow_osc

// [sim/tb_top.sv]
// Self-checking bench for the baseband clock control block
`timescale 1ns/1ns
module tb_top;
  import bcc_pkg::*;
  logic        i_core_clk;
  logic        i_reset;
  logic        run;
  bcc_wb_req_t req;
  bcc_wb_rsp_t rsp;
  logic        slow, cpu, codec, conv, fosc, rad, dsp, gp, ser, sec, fst;
  logic [2:0]  pll;
  logic [31:0] rd;
  logic [7:0]  vals [4] = '{8'hFF, 8'h2A, 8'h15, 8'h00};
  int          errors;
  int          tests_run;
  bcc_top bcc_top_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_wb_req(req), .o_wb_rsp(rsp),
    .i_slow_crystal_in(slow), .o_cpu_clk(cpu), .o_codec_clk(codec),
    .o_converter_clock_out(conv), .o_fast_osc_power_ctl(fosc), .o_radio_power_ctl(rad),
    .o_dsp_power_ctl(dsp), .o_gp_power_ctl(gp), .o_serial_conn_clock_enable(ser),
    .o_second_port_clock_enable(sec), .o_first_port_clock_enable(fst),
    .o_signal_proc_pll_setting(pll));
  bcc_slow_osc bcc_slow_osc_i (.i_core_clk(i_core_clk), .i_run(run), .o_slow(slow));
  initial
  begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for the answer however long it takes; only the watchdog ends a hang
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge i_core_clk);
    req <= '{1'b1, 1'b1, we, a, s, d};
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    check(n, 32'h2);
    req <= '{default: 1'b0};
  endtask
  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    errors = 0;
    tests_run = 0;
    i_reset = 1'b1;
    run = 1'b0;
    req = '{default: 1'b0};
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
    wb(1'b0, 12'h0B4, 32'h0);
    check(rd, {24'h0, PWR_EXT_RESET});
    @(posedge i_core_clk);
    #5;
    check({29'h0, cpu, codec, conv}, 32'h7);
    #10;
    check({29'h0, cpu, codec, conv}, 32'h0);
    wb(1'b1, 12'h0B4, 32'h16);
    repeat (3) @(posedge i_core_clk);
    #5;
    check({29'h0, cpu, codec, conv}, 32'h6);
    check({29'h0, gp, dsp, rad}, 32'h7);
    wb(1'b0, 12'h0B4, 32'h0);
    check(rd, 32'h16);
    wb(1'b1, 12'h0B4, 32'h20);
    repeat (3) @(posedge i_core_clk);
    #5;
    check({29'h0, cpu, codec, conv}, 32'h7);
    foreach (vals[k])
    begin
      wb(1'b1, 12'h154, {24'h0, vals[k]});
      check({26'h0, ser, sec, fst, pll}, {26'h0, vals[k][5:0]});
      wb(1'b0, 12'h154, 32'h0);
      check(rd, {24'h0, vals[k] & CEP_MASK});
    end
    wb(1'b0, 12'h100, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 12'h1C0, 32'h1);
    repeat (5) @(posedge i_core_clk);
    check({31'h0, fosc}, 32'h1);
    run <= 1'b1;
    repeat (4000) @(posedge i_core_clk);
    check({31'h0, fosc}, 32'h0);
    run <= 1'b0;
    repeat (3300) @(posedge i_core_clk);
    check({31'h0, fosc}, 32'h1);
    wb(1'b0, 12'h1C4, 32'h0);
    check(rd, 32'h0E);
    wb(1'b1, 12'h1C4, 32'h08);
    wb(1'b0, 12'h1C4, 32'h0);
    check(rd, 32'h06);
    // Writes without lane 0 or off the word boundary are ignored
    wb(1'b1, 12'h154, 32'h3F, 4'h0);
    wb(1'b1, 12'h155, 32'h3F);
    wb(1'b0, 12'h154, 32'h0);
    check(rd, 32'h0);
    check({26'h0, ser, sec, fst, pll}, 32'h0);
    // Reset in mid-run must reopen a closed gate
    wb(1'b1, 12'h0B4, 32'h16);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #5;
    check({29'h0, gp, dsp, conv}, 32'h1);
    @(posedge i_core_clk);
    i_reset <= 1'b0;
    wb(1'b0, 12'h0B4, 32'h0);
    check(rd, {24'h0, PWR_EXT_RESET});
    check({31'h0, fosc}, 32'h1);
    end_of_test();
  end
  // Run needs about 7400 cycles; the limit leaves ample margin
  initial
  begin
    #300000;
    errors++;
    end_of_test();
  end
endmodule // tb_top
